// ---- dv/mem_model.sv ----
// Memory-side partner model: pending memory work and data cache parity level
`timescale 1ns/1ps
module mem_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] pend,
	input  wire logic       load,
	input  wire logic       bad_parity,
	output logic            mem_idle,
	output logic            parity_err
);
	logic [3:0] left_reg;

	// One pending operation retires per cycle; a large load gives a slow answer
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			left_reg <= 4'h0;
		else if (load)
			left_reg <= pend;
		else if (left_reg != 4'h0)
			left_reg <= left_reg - 4'h1;
	end
	assign mem_idle   = (left_reg == 4'h0);
	// Held as a level so that only the command that reads the cache may use it
	assign parity_err = bad_parity;
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench: command decode, fault registers, slot remap, line allocate
`timescale 1ns/1ps
module testbench;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 ce = 1'b1;
	sysctl_pkg::cop_req_t req = '0;
	sysctl_pkg::abort_t   abort_in = '0;
	sysctl_pkg::maint_t   maint;
	logic [31:0]          iva = 32'h0;
	logic [31:0]          dva = 32'h0;
	logic [31:0]          rdata, maint_addr, iva_mapped, dva_mapped, btb_va, d, v, x;
	logic                 rvalid, busy, maint_parity_fault, mem_idle, parity_err;
	logic [3:0]           pend = 4'h0;
	logic                 load = 1'b0;
	logic                 bad_parity = 1'b0;
	logic [31:0]          seed = 32'h53E1FB20;
	logic [31:0]          rq[$];
	logic [43:0]          mq[$];
	logic [23:0]          cmd[12] = '{24'h707A20, 24'h705820, 24'h715400, 24'h706200,
		24'h716100, 24'h71A080, 24'h74A040, 24'h765020, 24'hA04008, 24'hA08004,
		24'hA14002, 24'hA18001};
	int                   mismatches = 0;
	int                   checks_done = 0;
	int                   faults = 0;
	int                   cyc = 0;
	int                   n;

	sysctl_cache_tlb_fault_remap dut (.clk(clk), .rst(rst), .ce(ce), .req(req),
		.abort_in(abort_in), .mem_idle(mem_idle), .parity_err(parity_err), .iva(iva),
		.dva(dva), .rdata(rdata), .rvalid(rvalid), .busy(busy), .maint(maint),
		.maint_addr(maint_addr), .maint_parity_fault(maint_parity_fault),
		.iva_mapped(iva_mapped), .dva_mapped(dva_mapped), .btb_va(btb_va));
	mem_model mem (.clk(clk), .rst(rst), .pend(pend), .load(load),
		.bad_parity(bad_parity), .mem_idle(mem_idle), .parity_err(parity_err));

	initial begin
		forever #4 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check_word(input logic [31:0] exp, input logic [31:0] act);
		checks_done++;
		if (act !== exp) begin
			mismatches++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, act);
		end
	endtask

	task automatic check_maint(input logic [43:0] exp, input logic [43:0] act);
		checks_done++;
		if (act !== exp) begin
			mismatches++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, act);
		end
	endtask

	task automatic report_and_stop;
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Requests stay valid back to back; gap drops valid for one cycle
	task automatic mv(input logic w, input logic [3:0] crn, input logic [2:0] op2,
		input logic [3:0] secondary_register_selector, input logic [31:0] dat);
		req <= {1'b1, w, crn, op2, secondary_register_selector, dat};
		@(posedge clk);
		#1;
	endtask

	task automatic gap;
		req <= '0;
		@(posedge clk);
		#1;
	endtask

	task automatic abort_pulse(input logic [42:0] a);
		abort_in <= a;
		@(posedge clk);
		#1 abort_in <= '0;
	endtask

	// Monitor: any strobe or read answer must match the oldest note
	always @(posedge clk) begin
		if (!rst && rvalid === 1'b1)
			check_word(rq.size() ? rq.pop_front() : ~rdata, rdata);
		if (!rst && maint !== '0)
			check_maint(mq.size() ? mq.pop_front() : ~{maint, maint_addr}, {maint, maint_addr});
		if (!rst && maint_parity_fault === 1'b1)
			faults++;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		#1 rst <= 1'b0;
		@(posedge clk);
		#1;
		rq.push_back(32'h0);
		mv(1'b0, 4'hD, 3'h0, 4'h0, rnd());
		rq.push_back(32'h0);
		mv(1'b0, 4'h3, 3'h0, 4'h0, rnd());
		mq.push_back({12'h020, 32'h0A123456});
		mv(1'b1, 4'hD, 3'h0, 4'h0, 32'h0A123456);
		rq.push_back(32'h0A000000);
		mv(1'b0, 4'hD, 3'h0, 4'h0, rnd());
		gap();
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			if (i[0])
				v[31:25] = 7'h00;
			x = (v[31:25] == 7'h00) ? {7'h05, v[24:0]} : v;
			iva <= v;
			dva <= ~v;
			repeat (2) @(posedge clk);
			#1;
			check_word(x, iva_mapped);
			check_word((~v) | ((v[31:25] == 7'h7F) ? 32'h0A000000 : 32'h0), dva_mapped);
			check_word(v, btb_va);
		end
		// All twelve maintenance commands are issued back to back with parity error held high
		// Command registers are written only, never read back
		bad_parity <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			d = rnd();
			mq.push_back({cmd[i][11:0], d});
			mv(1'b1, cmd[i][23:20], cmd[i][18:16], cmd[i][15:12], d);
		end
		mv(1'b1, 4'h7, 3'h2, 4'h7, rnd());
		mv(1'b1, 4'h7, 3'h0, 4'h2, rnd());
		gap();
		repeat (3) @(posedge clk);
		#1 bad_parity <= 1'b0;
		check_word(32'h1, 32'(faults));
		d = rnd();
		mq.push_back({12'h010, d & 32'hFFFFFFE0});
		pend <= 4'h6;
		load <= 1'b1;
		mv(1'b1, 4'h7, 3'h5, 4'h2, d);
		load <= 1'b0;
		mv(1'b1, 4'hD, 3'h0, 4'h0, 32'hFE000000);
		gap();
		n = 0;
		while (busy !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		#1;
		check_word(32'h1, 32'(n >= 4 && n < 50));
		rq.push_back(32'h0A000000);
		mv(1'b0, 4'hD, 3'h0, 4'h0, rnd());
		mv(1'b1, 4'h5, 3'h0, 4'h0, 32'hFFFFFFFF);
		rq.push_back(32'h000006FF);
		mv(1'b0, 4'h5, 3'h0, 4'h0, rnd());
		gap();
		d = rnd();
		abort_pulse({3'b110, 4'hC, 4'h7, d});
		rq.push_back(32'h000004C7);
		mv(1'b0, 4'h5, 3'h0, 4'h0, rnd());
		rq.push_back(d);
		mv(1'b0, 4'h6, 3'h0, 4'h0, rnd());
		gap();
		abort_pulse({3'b101, 4'h3, 4'h2, ~d});
		rq.push_back(32'h00000232);
		mv(1'b0, 4'h5, 3'h0, 4'h0, rnd());
		gap();
		// A slot write with the enable low must leave no strobe and no new slot
		ce <= 1'b0;
		mv(1'b1, 4'hD, 3'h0, 4'h0, 32'h02000000);
		gap();
		ce <= 1'b1;
		rq.push_back(32'h0A000000);
		mv(1'b0, 4'hD, 3'h0, 4'h0, rnd());
		gap();
		repeat (4) @(posedge clk);
		check_word(32'h0, 32'(rq.size() + mq.size()));
		report_and_stop();
	end
endmodule

// ---- verilog/sysctl_cache_tlb_fault_remap.sv ----
// Fault registers, cache and TLB maintenance decode, and process-slot remapping
// Operation
// - Fault status bit 10 extends the status code for prefetch and data aborts.
// - Fault status bit 9 flags a debug event; cause lives in method-of-entry field.
// - Fault status bits 7:4 record the accessed protection domain on data abort.
// - Fault status bits 3:0 hold the abort status code.
// - Fault address captures the modified virtual address of the aborting access.
// - Drain command empties both write buffer and fill buffer before completing.
// - Maintenance commands never check permissions nor raise translation, domain, permission faults.
// - Single instruction-line invalidate leaves the branch target buffer alone.
// - Cache enable state never changes contents; commands work either way.
// - Only clean data-line may raise a parity fault.
// - Whole-cache invalidate encodings and standalone branch target buffer invalidate.
// - Line allocate places tag from bits 31:5, evicting dirty other line.
// - Line allocate drains pending operations first, skips resident lines, never mini cache.
// - Allocated line starts clean; a later store makes it dirty.
// - TLB commands work and entries persist regardless of translation enable.
// - Lock instruction or data TLB entry for address; unlock respective TLB.
// - Zero address bits 31:25 get the seven-bit slot ORed in.
// - Remapped address feeds both caches and both TLBs.
// - Branch buffer uses raw address; slot write invalidates whole buffer.
// - Slot register at subselector 0, selector 0; resets zero, low bits read zero.
// - Abort handler entry loads fault status with exception source.
`timescale 1ns/1ps
module sysctl_cache_tlb_fault_remap (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                ce,
	input  wire sysctl_pkg::cop_req_t req,
	input  wire sysctl_pkg::abort_t  abort_in,
	input  wire logic                mem_idle,
	input  wire logic                parity_err,
	input  wire logic [31:0]         iva,
	input  wire logic [31:0]         dva,
	output logic [31:0]              rdata,
	output logic                     rvalid,
	output logic                     busy,
	output sysctl_pkg::maint_t       maint,
	output logic [31:0]              maint_addr,
	output logic                     maint_parity_fault,
	output logic [31:0]              iva_mapped,
	output logic [31:0]              dva_mapped,
	output logic [31:0]              btb_va
);
	logic [31:0]               fault_status_reg;
	logic [31:0]               fault_address_reg;
	logic [6:0]                process_slot_reg;
	sysctl_pkg::alloc_state_t  alloc_state_reg;
	logic [31:0]               alloc_addr_reg;
	logic                      clean_pending_reg;
	logic                      wr;
	logic                      rd;
	logic                      busy_next;
	sysctl_pkg::maint_t        maint_next;

	// Exact encoding match is the only path to a command
	assign wr = req.valid && req.write && !busy;
	assign rd = req.valid && !req.write;

	function automatic logic hit(input logic [3:0] crn, input logic [2:0] op2,
		input logic [3:0] secondary_register_selector);
		hit = wr && req.crn == crn && req.op2 == op2 && req.secondary_register_selector == secondary_register_selector;
	endfunction

	always_comb begin
		maint_next = '0;
		maint_next.inv_icache      = hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_0,
			sysctl_pkg::CRM_BOTH) || hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_0,
			sysctl_pkg::CRM_ICACHE);
		maint_next.inv_dcache      = hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_0,
			sysctl_pkg::CRM_BOTH) || hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_0,
			sysctl_pkg::CRM_DCACHE);
		// Line invalidate strobes no buffer flush on purpose
		maint_next.inv_icache_line = hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_1,
			sysctl_pkg::CRM_ICACHE);
		maint_next.inv_dcache_line = hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_1,
			sysctl_pkg::CRM_DCACHE);
		maint_next.clean_dline     = hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_1,
			sysctl_pkg::CRM_CLEAN);
		maint_next.drain           = hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_DRAIN,
			sysctl_pkg::CRM_CLEAN);
		maint_next.inv_btb         = maint_next.inv_icache
			|| hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_BTB, sysctl_pkg::CRM_ICACHE)
			|| hit(sysctl_pkg::CRN_SLOT, sysctl_pkg::OP2_0, sysctl_pkg::CRM_ZERO);
		maint_next.lock_itlb       = hit(sysctl_pkg::CRN_TLB_LOCK, sysctl_pkg::OP2_0,
			sysctl_pkg::CRM_ITLB);
		maint_next.lock_dtlb       = hit(sysctl_pkg::CRN_TLB_LOCK, sysctl_pkg::OP2_0,
			sysctl_pkg::CRM_DTLB);
		maint_next.unlock_itlb     = hit(sysctl_pkg::CRN_TLB_LOCK, sysctl_pkg::OP2_1,
			sysctl_pkg::CRM_ITLB);
		maint_next.unlock_dtlb     = hit(sysctl_pkg::CRN_TLB_LOCK, sysctl_pkg::OP2_1,
			sysctl_pkg::CRM_DTLB);
		// Allocate strobe only leaves the sequencer after memory has drained
		maint_next.alloc_line      = alloc_state_reg == sysctl_pkg::ST_ISSUE;
	end

	// Strobes ignore translation and cache enables entirely
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			maint      <= '0;
			maint_addr <= sysctl_pkg::WORD_ZERO;
		end else if (ce) begin
			maint <= maint_next;
			if (alloc_state_reg == sysctl_pkg::ST_ISSUE)
				maint_addr <= alloc_addr_reg;
			else if (wr)
				maint_addr <= req.data;
		end
	end

	// Line allocate: drain all pending memory traffic first, then issue the tag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alloc_state_reg <= sysctl_pkg::ST_IDLE;
			alloc_addr_reg  <= sysctl_pkg::WORD_ZERO;
		end else if (ce) begin
			unique case (alloc_state_reg)
				sysctl_pkg::ST_IDLE: begin
					if (hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_ALLOC,
						sysctl_pkg::CRM_ALLOC)) begin
						// Low five bits cleared: the tag alone names the line
						alloc_addr_reg  <= {req.data[31:sysctl_pkg::LINE_LO],
							5'h00};
						alloc_state_reg <= sysctl_pkg::ST_DRAIN;
					end
				end
				sysctl_pkg::ST_DRAIN: begin
					if (mem_idle)
						alloc_state_reg <= sysctl_pkg::ST_ISSUE;
				end
				sysctl_pkg::ST_ISSUE: alloc_state_reg <= sysctl_pkg::ST_IDLE;
				default: alloc_state_reg <= sysctl_pkg::ST_IDLE;
			endcase
		end
	end

	// Resident check, dirty eviction, clean start and mini-cache exclusion are in the data cache
	// itself; this block only delivers the tag once memory is quiet.

	assign busy_next = alloc_state_reg == sysctl_pkg::ST_IDLE ? 1'b0
		: alloc_state_reg == sysctl_pkg::ST_DRAIN;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			busy <= 1'b0;
		else if (ce)
			busy <= (wr && hit(sysctl_pkg::CRN_CACHE_FN, sysctl_pkg::OP2_ALLOC,
				sysctl_pkg::CRM_ALLOC)) || busy_next;
	end

	// Parity fault gated to the clean-line command alone; no other fault is ever raised
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clean_pending_reg  <= 1'b0;
			maint_parity_fault <= 1'b0;
		end else if (ce) begin
			clean_pending_reg  <= maint_next.clean_dline;
			maint_parity_fault <= clean_pending_reg && parity_err;
		end
	end

	// Fault status: abort report on handler entry outranks a software write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_status_reg <= sysctl_pkg::WORD_ZERO;
		end else if (ce) begin
			if (abort_in.valid) begin
				fault_status_reg <= sysctl_pkg::WORD_ZERO;
				fault_status_reg[sysctl_pkg::FS_EXT_BIT] <= abort_in.ext;
				fault_status_reg[sysctl_pkg::FS_DBG_BIT] <= abort_in.debug;
				fault_status_reg[sysctl_pkg::FS_DOM_HI:sysctl_pkg::FS_DOM_LO]
					<= abort_in.domain;
				fault_status_reg[sysctl_pkg::FS_STAT_HI:sysctl_pkg::FS_STAT_LO]
					<= abort_in.status;
			end else if (hit(sysctl_pkg::CRN_FAULT_STAT, sysctl_pkg::OP2_0,
				sysctl_pkg::CRM_ZERO)) begin
				fault_status_reg <= req.data & sysctl_pkg::FS_WMASK;
			end
		end
	end

	// Fault address holds the remapped address of the aborting data access
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_address_reg <= sysctl_pkg::WORD_ZERO;
		end else if (ce) begin
			if (abort_in.valid && !abort_in.debug)
				fault_address_reg <= abort_in.addr;
			else if (hit(sysctl_pkg::CRN_FAULT_ADDR, sysctl_pkg::OP2_0,
				sysctl_pkg::CRM_ZERO))
				fault_address_reg <= req.data;
		end
	end

	// Process slot register; only the top seven bits are stored
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			process_slot_reg <= sysctl_pkg::SLOT_RESET;
		else if (ce && hit(sysctl_pkg::CRN_SLOT, sysctl_pkg::OP2_0, sysctl_pkg::CRM_ZERO))
			process_slot_reg <= req.data[sysctl_pkg::SLOT_HI:sysctl_pkg::SLOT_LO];
	end

	// Registered remap adds one cycle of latency before every cache and TLB lookup
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			iva_mapped <= sysctl_pkg::WORD_ZERO;
			dva_mapped <= sysctl_pkg::WORD_ZERO;
			btb_va     <= sysctl_pkg::WORD_ZERO;
		end else if (ce) begin
			iva_mapped <= sysctl_pkg::remap(iva, process_slot_reg);
			dva_mapped <= sysctl_pkg::remap(dva, process_slot_reg);
			btb_va     <= iva;
		end
	end

	// Read path; command registers answer zero since their reads are undefined
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata  <= sysctl_pkg::WORD_ZERO;
			rvalid <= 1'b0;
		end else if (ce) begin
			rvalid <= rd;
			rdata  <= sysctl_pkg::WORD_ZERO;
			if (rd && req.op2 == sysctl_pkg::OP2_0 && req.secondary_register_selector == sysctl_pkg::CRM_ZERO) begin
				unique case (req.crn)
					sysctl_pkg::CRN_FAULT_STAT: rdata <= fault_status_reg;
					sysctl_pkg::CRN_FAULT_ADDR: rdata <= fault_address_reg;
					sysctl_pkg::CRN_SLOT: rdata <= {process_slot_reg, 25'h0000000};
					default: rdata <= sysctl_pkg::WORD_ZERO;
				endcase
			end
		end
	end

	a_slot_remap_zero: assert property (@(posedge clk) disable iff (rst)
		ce && dva[31:25] == 7'h00 |=> dva_mapped[31:25] == $past(process_slot_reg))
		else $error("zero top bits not remapped with slot");
	a_slot_remap_pass: assert property (@(posedge clk) disable iff (rst)
		ce && iva[31:25] != 7'h00 |=> iva_mapped == $past(iva))
		else $error("nonzero top bits were altered");
	a_btb_raw_addr: assert property (@(posedge clk) disable iff (rst)
		ce |=> btb_va == $past(iva))
		else $error("branch buffer address was remapped");
	a_slot_write_btb: assert property (@(posedge clk) disable iff (rst)
		ce && wr && req.crn == 4'hD && req.op2 == 3'h0 && req.secondary_register_selector == 4'h0 |=> maint.inv_btb)
		else $error("slot write did not flush branch buffer");
	a_line_no_btb: assert property (@(posedge clk) disable iff (rst)
		ce && wr && req.crn == 4'h7 && req.op2 == 3'h1 && req.secondary_register_selector == 4'h5
		|=> maint.inv_icache_line && !maint.inv_btb)
		else $error("line invalidate touched branch buffer");
	a_drain_decode: assert property (@(posedge clk) disable iff (rst)
		ce && wr && req.crn == 4'h7 && req.op2 == 3'h4 && req.secondary_register_selector == 4'hA |=> maint.drain)
		else $error("drain not issued");
	a_alloc_waits: assert property (@(posedge clk) disable iff (rst)
		maint.alloc_line |-> $past(mem_idle, 2))
		else $error("allocate issued before memory drained");
	a_parity_only_clean: assert property (@(posedge clk) disable iff (rst)
		maint_parity_fault |-> $past(maint.clean_dline))
		else $error("parity fault outside clean line");
	a_abort_loads: assert property (@(posedge clk) disable iff (rst)
		ce && abort_in.valid |=> fault_status_reg[7:4] == $past(abort_in.domain)
		&& fault_status_reg[3:0] == $past(abort_in.status))
		else $error("fault status not loaded on abort");
	a_slot_low_zero: assert property (@(posedge clk) disable iff (rst)
		rvalid && $past(req.crn) == 4'hD |-> rdata[24:0] == 25'h0000000)
		else $error("slot low bits not zero");
endmodule

// ---- verilog/sysctl_pkg.sv ----
// Shared constants and carriers for the system-control fault, maintenance and remap block
package sysctl_pkg;
	localparam int          CRN_W          = 4;
	localparam int          OP2_W          = 3;
	localparam int          CRM_W          = 4;
	localparam logic [3:0]  CRN_FAULT_STAT = 4'h5;
	localparam logic [3:0]  CRN_FAULT_ADDR = 4'h6;
	localparam logic [3:0]  CRN_CACHE_FN   = 4'h7;
	localparam logic [3:0]  CRN_TLB_LOCK   = 4'hA;
	localparam logic [3:0]  CRN_SLOT       = 4'hD;
	localparam logic [2:0]  OP2_0          = 3'h0;
	localparam logic [2:0]  OP2_1          = 3'h1;
	localparam logic [2:0]  OP2_DRAIN      = 3'h4;
	localparam logic [2:0]  OP2_ALLOC      = 3'h5;
	localparam logic [2:0]  OP2_BTB        = 3'h6;
	localparam logic [3:0]  CRM_ZERO       = 4'h0;
	localparam logic [3:0]  CRM_ALLOC      = 4'h2;
	localparam logic [3:0]  CRM_ITLB       = 4'h4;
	localparam logic [3:0]  CRM_ICACHE     = 4'h5;
	localparam logic [3:0]  CRM_DCACHE     = 4'h6;
	localparam logic [3:0]  CRM_BOTH       = 4'h7;
	localparam logic [3:0]  CRM_DTLB       = 4'h8;
	localparam logic [3:0]  CRM_CLEAN      = 4'hA;
	localparam int          FS_EXT_BIT     = 10;
	localparam int          FS_DBG_BIT     = 9;
	localparam int          FS_DOM_HI      = 7;
	localparam int          FS_DOM_LO      = 4;
	localparam int          FS_STAT_HI     = 3;
	localparam int          FS_STAT_LO     = 0;
	localparam logic [31:0] FS_WMASK       = 32'h0000_06FF;
	localparam int          SLOT_HI        = 31;
	localparam int          SLOT_LO        = 25;
	localparam int          LINE_LO        = 5;
	localparam logic [6:0]  SLOT_RESET     = 7'h00;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

	// One coprocessor move from the core pipeline
	typedef struct packed {
		logic             valid;
		logic             write;
		logic [3:0]       crn;
		logic [2:0]       op2;
		logic [3:0]       secondary_register_selector;
		logic [31:0]      data;
	} cop_req_t;

	// Abort report from the core on handler entry
	typedef struct packed {
		logic             valid;
		logic             ext;
		logic             debug;
		logic [3:0]       domain;
		logic [3:0]       status;
		logic [31:0]      addr;
	} abort_t;

	// One-cycle maintenance command strobes toward caches and TLBs
	typedef struct packed {
		logic             inv_icache;
		logic             inv_icache_line;
		logic             inv_dcache;
		logic             inv_dcache_line;
		logic             clean_dline;
		logic             drain;
		logic             inv_btb;
		logic             alloc_line;
		logic             lock_itlb;
		logic             lock_dtlb;
		logic             unlock_itlb;
		logic             unlock_dtlb;
	} maint_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_DRAIN = 2'b01,
		ST_ISSUE = 2'b11
	} alloc_state_t;

	function automatic logic [31:0] remap(input logic [31:0] va, input logic [6:0] slot);
		remap = va;
		if (va[SLOT_HI:SLOT_LO] == 7'h00)
			remap[SLOT_HI:SLOT_LO] = slot;
	endfunction
endpackage
